// ### hw/ousc_defines.svh
`ifndef OUSC_DEFINES_SVH
`define OUSC_DEFINES_SVH
`define OUSC_OBJ_SYMS        8'h09
`define OUSC_OBJ_TONES       8'h0a
`define OUSC_OBJ_SLOT        8'h0b
`define OUSC_OBJ_PREAMBLE    8'h0c
`define OUSC_OBJ_RXLVL       8'h0d
`define OUSC_OBJ_IR_TONES    8'h11
`define OUSC_OBJ_IR_GUARD    8'h12
`define OUSC_OBJ_FR_TONES    8'h21
`define OUSC_OBJ_FR_GUARD    8'h22
`define OUSC_OBJ_RNG_TONE    8'h33
`define OUSC_OBJ_RNG_COUNT   8'h34
`define OUSC_OBJ_RNG_PILOT   8'h35
`define OUSC_SYMS_MIN        8'h06
`define OUSC_SYMS_MAX        8'h20
`define OUSC_SYMS_RESET      8'h06
`define OUSC_PREAMBLE_MAX    8'hc0
`define OUSC_SLOT_MAX        8'hed
`define OUSC_PILOT_MIN       8'h01
`define OUSC_PILOT_MAX       8'h0e
`define OUSC_PILOT_RESET     8'h01
`define OUSC_NUM_CODES       7
`define OUSC_NUM_SLOTS       238
`endif

// ### hw/ousc_pkg.sv
package ousc_pkg;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  obj;
      logic [7:0]  code;
      logic [7:0]  first_slot;
      logic [31:0] data;
   } ousc_req_s;
   typedef struct packed {
      logic        done;
      logic        ok;
      logic [31:0] data;
   } ousc_rsp_s;
   typedef struct packed {
      logic [15:0] first_tone;
      logic [15:0] slot_count;
      logic [7:0]  pilot;
   } ousc_range_s;
   typedef enum logic [2:0] {
      OUSC_IDLE = 3'b001,
      OUSC_PRE  = 3'b010,
      OUSC_RSP  = 3'b100
   } ousc_state_e;
endpackage : ousc_pkg

// ### hw/ousc_code_map.sv
`timescale 1ns/1ps
`default_nettype none
module ousc_code_map (
   // usage code key
   input  wire logic [7:0] code,
   // compact index and validity
   output logic [2:0]      index,
   output logic            valid
);
   always_comb begin
      valid = 1'b1;
      index = 3'h0;
      case (code)
         8'h05: index = 3'h0;
         8'h06: index = 3'h1;
         8'h09: index = 3'h2;
         8'h0a: index = 3'h3;
         8'h0b: index = 3'h4;
         8'h0c: index = 3'h5;
         8'h0d: index = 3'h6;
         default: valid = 1'b0;
      endcase
   end
endmodule : ousc_code_map
`default_nettype wire

// ### hw/ousc_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "ousc_defines.svh"
module ousc_store (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                nrst,
   // request and answer
   input  wire ousc_pkg::ousc_req_s req,
   input  wire logic [7:0]          pre_byte,
   output ousc_pkg::ousc_rsp_s      rsp,
   // preamble read port
   input  wire logic [7:0]          pre_rd_addr,
   output logic [7:0]               pre_rd_byte,
   output logic [7:0]               pre_len,
   // node slot counter
   input  wire logic [31:0]         slot_counter,
   // applied configuration
   output logic [7:0]               frame_symbol_count,
   output logic [15:0]              active_tone_count,
   output logic signed [15:0]       target_receive_level,
   output logic [15:0]              ir_tone_count,
   output logic [15:0]              ir_guard_band,
   output logic [15:0]              fr_tone_count,
   output logic [15:0]              fr_guard_band,
   output logic                     change_pending,
   output logic                     change_applied
);
   logic [1:0]                   rst_sync;
   logic                         rst_n;
   ousc_pkg::ousc_state_e        state_reg;
   logic [7:0]                   pre_cnt_reg;
   logic [7:0]                   pre_mem [0:191];
   logic [7:0]                   pre_len_reg;
   logic [7:0]                   syms_reg, syms_shadow;
   logic [15:0]                  tones_reg, tones_shadow;
   logic [15:0]                  rxlvl_reg, rxlvl_shadow;
   logic [15:0]                  irt_reg, irt_shadow, irg_reg, irg_shadow;
   logic [15:0]                  frt_reg, frt_shadow, frg_reg, frg_shadow;
   logic [31:0]                  slot_reg;
   logic                         pend_reg;
   ousc_pkg::ousc_range_s        rng_mem [0:`OUSC_NUM_CODES*`OUSC_NUM_SLOTS-1];
   logic [2:0]                   code_idx;
   logic                         code_ok;
   logic [10:0]                  rng_idx;
   logic                         key_ok;
   logic                         ok;
   logic [31:0]                  rd_data;
   logic                         wr, rd;
   ousc_pkg::ousc_range_s        rng_rd;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   ousc_code_map u_map (
      .code  (req.code),
      .index (code_idx),
      .valid (code_ok)
   );

   assign key_ok  = code_ok && (req.first_slot <= `OUSC_SLOT_MAX);
   assign rng_idx = 11'(code_idx) * 11'(`OUSC_NUM_SLOTS) + 11'(req.first_slot);
   assign rng_rd  = rng_mem[rng_idx];
   assign wr      = req.valid && req.write && state_reg == ousc_pkg::OUSC_IDLE;
   assign rd      = req.valid && !req.write && state_reg == ousc_pkg::OUSC_IDLE;

   // validity of the object value
   always_comb begin
      ok = 1'b1;
      case (req.obj)
         `OUSC_OBJ_SYMS:
            ok = req.data[31:8] == 24'h0 && req.data[7:0] >= `OUSC_SYMS_MIN
                 && req.data[7:0] <= `OUSC_SYMS_MAX;
         `OUSC_OBJ_TONES, `OUSC_OBJ_RXLVL, `OUSC_OBJ_IR_GUARD, `OUSC_OBJ_FR_GUARD:
            ok = req.data[31:16] == 16'h0;
         `OUSC_OBJ_SLOT: ok = 1'b1;
         `OUSC_OBJ_PREAMBLE:
            ok = req.data[31:8] == 24'h0 && req.data[7:0] <= `OUSC_PREAMBLE_MAX;
         `OUSC_OBJ_IR_TONES, `OUSC_OBJ_FR_TONES:
            ok = req.data[31:16] == 16'h0 && !req.data[0];
         `OUSC_OBJ_RNG_TONE, `OUSC_OBJ_RNG_COUNT:
            ok = key_ok && req.data[31:16] == 16'h0;
         `OUSC_OBJ_RNG_PILOT:
            ok = key_ok && req.data[31:8] == 24'h0 && req.data[7:0] >= `OUSC_PILOT_MIN
                 && req.data[7:0] <= `OUSC_PILOT_MAX;
         default: ok = 1'b0;
      endcase
   end

   // read mux
   always_comb begin
      rd_data = 32'h0;
      case (req.obj)
         `OUSC_OBJ_SYMS:      rd_data = {24'h0, syms_shadow};
         `OUSC_OBJ_TONES:     rd_data = {16'h0, tones_shadow};
         `OUSC_OBJ_SLOT:      rd_data = 32'h0;
         `OUSC_OBJ_PREAMBLE:  rd_data = {24'h0, pre_len_reg};
         `OUSC_OBJ_RXLVL:     rd_data = {16'h0, rxlvl_shadow};
         `OUSC_OBJ_IR_TONES:  rd_data = {16'h0, irt_shadow};
         `OUSC_OBJ_IR_GUARD:  rd_data = {16'h0, irg_shadow};
         `OUSC_OBJ_FR_TONES:  rd_data = {16'h0, frt_shadow};
         `OUSC_OBJ_FR_GUARD:  rd_data = {16'h0, frg_shadow};
         `OUSC_OBJ_RNG_TONE:  rd_data = {16'h0, rng_rd.first_tone};
         `OUSC_OBJ_RNG_COUNT: rd_data = {16'h0, rng_rd.slot_count};
         `OUSC_OBJ_RNG_PILOT: rd_data = {24'h0, rng_rd.pilot};
         default:             rd_data = 32'h0;
      endcase
   end

   // request sequencing; preamble takes one byte per cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= ousc_pkg::OUSC_IDLE;
         pre_cnt_reg <= 8'h0;
         pre_len_reg <= 8'h0;
         rsp         <= '0;
      end else begin
         rsp.done <= 1'b0;
         case (state_reg)
            ousc_pkg::OUSC_IDLE: begin
               if (wr && ok && req.obj == `OUSC_OBJ_PREAMBLE && req.data[7:0] != 8'h0) begin
                  state_reg   <= ousc_pkg::OUSC_PRE;
                  pre_cnt_reg <= 8'h0;
                  pre_len_reg <= req.data[7:0];
               end else if (req.valid) begin
                  state_reg <= ousc_pkg::OUSC_RSP;
                  rsp.ok    <= req.write ? ok : (req.obj != `OUSC_OBJ_RNG_TONE && req.obj !=
                               `OUSC_OBJ_RNG_COUNT && req.obj != `OUSC_OBJ_RNG_PILOT) || key_ok;
                  rsp.data  <= req.write ? 32'h0 : rd_data;
                  if (wr && ok && req.obj == `OUSC_OBJ_PREAMBLE) begin
                     pre_len_reg <= 8'h0;
                  end
               end
            end
            ousc_pkg::OUSC_PRE: begin
               pre_cnt_reg <= pre_cnt_reg + 8'h1;
               if (pre_cnt_reg + 8'h1 == pre_len_reg) begin
                  state_reg <= ousc_pkg::OUSC_RSP;
                  rsp.ok    <= 1'b1;
                  rsp.data  <= 32'h0;
               end
            end
            ousc_pkg::OUSC_RSP: begin
               rsp.done  <= 1'b1;
               state_reg <= ousc_pkg::OUSC_IDLE;
            end
            default: state_reg <= ousc_pkg::OUSC_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (state_reg == ousc_pkg::OUSC_PRE) begin
         pre_mem[pre_cnt_reg] <= pre_byte;
      end
      pre_rd_byte <= pre_mem[pre_rd_addr];
   end
   assign pre_len = pre_len_reg;

   always_ff @(posedge sys_clk) begin
      if (wr && ok) begin
         case (req.obj)
            `OUSC_OBJ_RNG_TONE:  rng_mem[rng_idx].first_tone <= req.data[15:0];
            `OUSC_OBJ_RNG_COUNT: rng_mem[rng_idx].slot_count <= req.data[15:0];
            `OUSC_OBJ_RNG_PILOT: rng_mem[rng_idx].pilot      <= req.data[7:0];
            default: ;
         endcase
      end
   end

   // shadow copies written by the core; rejected writes leave them unchanged
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         syms_shadow  <= `OUSC_SYMS_RESET;
         tones_shadow <= 16'h0;
         rxlvl_shadow <= 16'h0;
         irt_shadow   <= 16'h0;
         irg_shadow   <= 16'h0;
         frt_shadow   <= 16'h0;
         frg_shadow   <= 16'h0;
      end else if (wr && ok) begin
         case (req.obj)
            `OUSC_OBJ_SYMS:     syms_shadow  <= req.data[7:0];
            `OUSC_OBJ_TONES:    tones_shadow <= req.data[15:0];
            `OUSC_OBJ_RXLVL:    rxlvl_shadow <= req.data[15:0];
            `OUSC_OBJ_IR_TONES: irt_shadow   <= req.data[15:0];
            `OUSC_OBJ_IR_GUARD: irg_shadow   <= req.data[15:0];
            `OUSC_OBJ_FR_TONES: frt_shadow   <= req.data[15:0];
            `OUSC_OBJ_FR_GUARD: frg_shadow   <= req.data[15:0];
            default: ;
         endcase
      end
   end

   // deferred change: new write of the slot object arms it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_reg       <= 32'h0;
         pend_reg       <= 1'b0;
         change_applied <= 1'b0;
      end else begin
         change_applied <= 1'b0;
         if (wr && req.obj == `OUSC_OBJ_SLOT) begin
            slot_reg <= req.data;
            pend_reg <= 1'b1;
         end else if (pend_reg && slot_counter == slot_reg) begin
            pend_reg       <= 1'b0;
            change_applied <= 1'b1;
         end
      end
   end
   assign change_pending = pend_reg;

   // applied configuration follows the shadows at the chosen slot
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         syms_reg  <= `OUSC_SYMS_RESET;
         tones_reg <= 16'h0;
         rxlvl_reg <= 16'h0;
         irt_reg   <= 16'h0;
         irg_reg   <= 16'h0;
         frt_reg   <= 16'h0;
         frg_reg   <= 16'h0;
      end else if (pend_reg && slot_counter == slot_reg && !(wr && req.obj == `OUSC_OBJ_SLOT)) begin
         syms_reg  <= syms_shadow;
         tones_reg <= tones_shadow;
         rxlvl_reg <= rxlvl_shadow;
         irt_reg   <= irt_shadow;
         irg_reg   <= irg_shadow;
         frt_reg   <= frt_shadow;
         frg_reg   <= frg_shadow;
      end
   end
   assign frame_symbol_count   = syms_reg;
   assign active_tone_count    = tones_reg;
   assign target_receive_level = signed'(rxlvl_reg);
   assign ir_tone_count        = irt_reg;
   assign ir_guard_band        = irg_reg;
   assign fr_tone_count        = frt_reg;
   assign fr_guard_band        = frg_reg;

   AST_SYMS_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      syms_shadow >= `OUSC_SYMS_MIN && syms_shadow <= `OUSC_SYMS_MAX)
      else $error("symbol count out of range");
   AST_SYMS_APPLIED: assert property (@(posedge sys_clk) disable iff (!rst_n)
      syms_reg >= `OUSC_SYMS_MIN && syms_reg <= `OUSC_SYMS_MAX)
      else $error("applied symbol count out of range");
   AST_SLOT_READ_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd && req.obj == `OUSC_OBJ_SLOT |=> ##1 rsp.done && rsp.data == 32'h0)
      else $error("slot object read not zero");
   AST_APPLY_AT_SLOT: assert property (@(posedge sys_clk) disable iff (!rst_n)
      change_applied |-> $past(slot_counter) == $past(slot_reg))
      else $error("change applied off slot");
   AST_HOLD_OFF_SLOT: assert property (@(posedge sys_clk) disable iff (!rst_n)
      slot_counter != slot_reg |=> $stable(syms_reg) && $stable(tones_reg) && $stable(rxlvl_reg))
      else $error("configuration moved off slot");
   AST_PRE_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pre_len_reg <= `OUSC_PREAMBLE_MAX)
      else $error("preamble too long");
   AST_PRE_END: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_reg == ousc_pkg::OUSC_PRE && pre_cnt_reg + 8'h1 == pre_len_reg |=> state_reg == ousc_pkg::OUSC_RSP)
      else $error("preamble stream did not end");
   AST_IR_EVEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !irt_shadow[0] && !frt_shadow[0])
      else $error("odd ranging tone count");
   AST_RXLVL_BACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr && ok && req.obj == `OUSC_OBJ_RXLVL |=> rxlvl_shadow == $past(req.data[15:0]))
      else $error("receive level not stored");
   AST_CODE_KEY: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr && !code_ok && (req.obj == `OUSC_OBJ_RNG_PILOT || req.obj == `OUSC_OBJ_RNG_TONE) |-> !ok)
      else $error("reserved usage code accepted");
   AST_REJECT_KEEPS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr && !ok && req.obj == `OUSC_OBJ_TONES |=> $stable(tones_shadow))
      else $error("rejected write changed value");
   AST_REJECT_RSP: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr && !ok |=> ##1 rsp.done && !rsp.ok)
      else $error("rejected write not reported");
   AST_DONE_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rsp.done |=> !rsp.done)
      else $error("answer strobe longer than one cycle");
   AST_TONES_BACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr && ok && req.obj == `OUSC_OBJ_TONES |=> tones_shadow == $past(req.data[15:0]))
      else $error("tone count not stored");
   COV_APPLY: cover property (@(posedge sys_clk) change_applied);
   COV_REJECT: cover property (@(posedge sys_clk) rsp.done && !rsp.ok);
   COV_PRE: cover property (@(posedge sys_clk) state_reg == ousc_pkg::OUSC_PRE);
   COV_SLOT_READ: cover property (@(posedge sys_clk) rd && req.obj == `OUSC_OBJ_SLOT);
endmodule : ousc_store
`default_nettype wire

// ### verification/ousc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ousc_ctrl_model (
   // clock
   input  wire logic                sys_clk,
   // request side
   output ousc_pkg::ousc_req_s      req,
   output logic [7:0]               pre_byte,
   // answer side
   input  wire ousc_pkg::ousc_rsp_s rsp
);
   initial begin
      req = '0;
      pre_byte = 8'h5a;
   end
   // one request held until done, preamble bytes streamed after take
   task automatic xfer(input logic wr, input logic [7:0] obj, input logic [7:0] code, input logic [7:0] slot,
                       input logic [31:0] data, input logic [7:0] base, output logic tmo);
      int n;
      @(negedge sys_clk);
      req = '{1'b1, wr, obj, code, slot, data};
      @(posedge sys_clk);
      for (n = 0; n < 400; n++) begin
         @(negedge sys_clk);
         if (rsp.done === 1'b1) break;
         if (wr && obj == 8'h0c && n < data) pre_byte = base ^ n[7:0];
         else pre_byte = ~pre_byte;
      end
      req.valid = 1'b0;
      req.data = ~req.data;
      pre_byte = ~pre_byte;
      tmo = (n == 400);
   endtask : xfer
endmodule : ousc_ctrl_model
`default_nettype wire

// ### verification/ousc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {logic ok; logic [31:0] data; logic [31:0] mask;} ousc_note_s;
   logic                sys_clk, nrst, change_pending, change_applied, tmo, okc;
   ousc_pkg::ousc_req_s req;
   ousc_pkg::ousc_rsp_s rsp;
   logic [7:0]          pre_byte, pre_rd_addr, pre_rd_byte, pre_len, frame_symbol_count, code_r, slot_r, base;
   logic [31:0]         slot_counter, lfsr, s;
   logic [15:0]         active_tone_count, ir_tone_count, ir_guard_band, fr_tone_count, fr_guard_band, t;
   logic signed [15:0]  target_receive_level;
   logic [15:0]         v [0:3];
   logic [7:0]          objs [0:3] = '{8'h11, 8'h12, 8'h21, 8'h22};
   ousc_note_s          notes [$];
   int                  error_cnt, checks, i;
   ousc_store u_dut (.sys_clk, .nrst, .req, .pre_byte, .rsp, .pre_rd_addr, .pre_rd_byte, .pre_len,
                     .slot_counter, .frame_symbol_count, .active_tone_count, .target_receive_level,
                     .ir_tone_count, .ir_guard_band, .fr_tone_count, .fr_guard_band, .change_pending,
                     .change_applied);
   ousc_ctrl_model u_ctrl (.sys_clk, .req, .pre_byte, .rsp);
   always #50 sys_clk = ~sys_clk;
   function automatic logic [31:0] next_rand(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : next_rand
   task automatic summarize;
      if (error_cnt == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk
   task automatic op(input logic w, input logic [7:0] obj, input logic [31:0] d, input logic ok,
                     input logic [31:0] ed, input logic [31:0] m);
      notes.push_back('{ok, ed, m});
      u_ctrl.xfer(w, obj, code_r, slot_r, d, base, tmo);
      if (tmo) begin
         error_cnt++;
         summarize();
      end
   endtask : op
   task automatic wr(input logic [7:0] obj, input logic [31:0] d, input logic ok);
      op(1'b1, obj, d, ok, 32'h0, 32'h0);
   endtask : wr
   task automatic rd(input logic [7:0] obj, input logic ok, input logic [31:0] ed, input logic [31:0] m);
      op(1'b0, obj, 32'h0, ok, ed, m);
   endtask : rd
   // answer monitor
   always @(negedge sys_clk) begin
      ousc_note_s n;
      if (rsp.done === 1'b1) begin
         if (notes.size() == 0) chk(32'h1, 32'h0);
         else begin
            n = notes.pop_front();
            chk({31'h0, n.ok}, {31'h0, rsp.ok});
            chk(n.data & n.mask, rsp.data & n.mask);
         end
      end
   end
   initial begin
      sys_clk = 1'b0;
      nrst = 1'b0;
      pre_rd_addr = 8'h00;
      slot_counter = 32'h0000_1234;
      lfsr = 32'hb70c;
      base = 8'h00;
      code_r = 8'h05;
      slot_r = 8'h00;
      repeat (3) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk(32'h6, {24'h0, frame_symbol_count});
      wr(8'h09, 32'h05, 1'b0);
      wr(8'h09, 32'h06, 1'b1);
      wr(8'h09, 32'h21, 1'b0);
      wr(8'h09, 32'h20, 1'b1);
      wr(8'h09, 32'h21, 1'b0);
      rd(8'h09, 1'b1, 32'h20, 32'hffff_ffff);
      lfsr = next_rand(lfsr);
      t = lfsr[15:0];
      wr(8'h0a, {16'h0, t}, 1'b1);
      wr(8'h0a, 32'h0001_0000, 1'b0);
      rd(8'h0a, 1'b1, {16'h0, t}, 32'hffff_ffff);
      for (i = 0; i < 4; i++) begin
         lfsr = next_rand(lfsr);
         v[i] = lfsr[15:0] & (i[0] ? 16'hffff : 16'hfffe);
         wr(objs[i], {16'h0, v[i] | 16'h1}, i[0]);
         wr(objs[i], {16'h0, v[i]}, 1'b1);
         rd(objs[i], 1'b1, {16'h0, v[i]}, 32'hffff_ffff);
      end
      wr(8'h0d, 32'h0000_ff38, 1'b1);
      rd(8'h0d, 1'b1, 32'h0000_ff38, 32'h0000_ffff);
      s = 32'h8000_1234;
      wr(8'h0b, s, 1'b1);
      rd(8'h0b, 1'b1, 32'h0, 32'hffff_ffff);
      repeat (3) @(negedge sys_clk);
      chk(32'h1, {31'h0, change_pending});
      chk(32'h6, {24'h0, frame_symbol_count});
      slot_counter = s;
      for (i = 0; i < 20 && change_applied !== 1'b1; i++) @(negedge sys_clk);
      if (i == 20) begin
         error_cnt++;
         summarize();
      end
      chk(32'h1, {31'h0, change_applied});
      chk(32'h20, {24'h0, frame_symbol_count});
      chk({16'h0, t}, {16'h0, active_tone_count});
      chk(32'hffff_ff38, 32'(target_receive_level));
      chk({v[0], v[1]}, {ir_tone_count, ir_guard_band});
      chk({v[2], v[3]}, {fr_tone_count, fr_guard_band});
      @(negedge sys_clk);
      chk(32'h0, {31'h0, change_pending});
      lfsr = next_rand(lfsr);
      base = lfsr[7:0];
      wr(8'h0c, 32'd192, 1'b1);
      wr(8'h0c, 32'd193, 1'b0);
      chk(32'd192, {24'h0, pre_len});
      for (i = 0; i < 192; i += 95) begin
         pre_rd_addr = i[7:0];
         @(negedge sys_clk);
         chk({24'h0, base ^ i[7:0]}, {24'h0, pre_rd_byte});
      end
      wr(8'h0c, 32'd0, 1'b1);
      chk(32'h0, {24'h0, pre_len});
      for (i = 0; i < 16; i++) begin
         code_r = i[7:0];
         okc = (i == 5 || i == 6 || (i >= 9 && i <= 13));
         wr(8'h35, 32'he, okc);
      end
      code_r = 8'h0d;
      slot_r = 8'hee;
      wr(8'h35, 32'h3, 1'b0);
      rd(8'h33, 1'b0, 32'h0, 32'h0);
      slot_r = 8'hed;
      wr(8'h35, 32'he, 1'b1);
      wr(8'h35, 32'h0, 1'b0);
      wr(8'h35, 32'hf, 1'b0);
      rd(8'h35, 1'b1, 32'he, 32'h0000_00ff);
      wr(8'h35, 32'h1, 1'b1);
      rd(8'h35, 1'b1, 32'h1, 32'h0000_00ff);
      lfsr = next_rand(lfsr);
      wr(8'h33, {16'h0, lfsr[15:0]}, 1'b1);
      wr(8'h34, {16'h0, lfsr[31:16]}, 1'b1);
      rd(8'h33, 1'b1, {16'h0, lfsr[15:0]}, 32'h0000_ffff);
      rd(8'h34, 1'b1, {16'h0, lfsr[31:16]}, 32'h0000_ffff);
      repeat (2) @(negedge sys_clk);
      chk(32'h0, notes.size());
      summarize();
   end
endmodule : tb_top
`default_nettype wire
